//--- core/bicolor_led_state_control.sv
// Purpose: drives two active-low open-drain indicator pins from the
//          led control register and platform sleep/power-good inputs
// Assumes: inputs synchronous to core_clk; rst is standby reset,
//          main_rail_rst is the main-rail reset
// Notes:
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module bicolor_led_state_control
    import led_indicator_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       main_rail_rst,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       soft_off_sleep_n,
    input  wire logic       suspend_ram_sleep_n,
    input  wire logic       supply_power_good,
    input  wire logic       first_indicator_in,
    input  wire logic       second_indicator_in,
    output logic            first_indicator_out,
    output logic            first_indicator_oe,
    output logic            second_indicator_out,
    output logic            second_indicator_oe
);
    pwr_state_t       state_ff;
    pwr_state_t       nxt_state;
    logic [3:0]       led_ctrl_ff;
    logic [1:0]       gpio_inv_ff;
    logic [CNT_W-1:0] blink_cnt_ff;
    logic             blink_ph_ff;
    logic             drive1;
    logic             drive2;
    logic             pin1;
    logic             pin2;

    // active (lit) level per pin before polarity
    function automatic logic [1:0] lit_of(input logic [3:0] c,
                                          input logic       ph);
        logic [1:0] r;
        logic       on;
        r  = 2'b00;
        on = (c[1:0] == MODE_STEADY) || (c[1:0] == MODE_BLINK && ph);
        if (c[BOOT_BIT] == c[HUE_BIT]) begin
            if (on) r = c[HUE_BIT] ? 2'b10 : 2'b01;
        end else if (c[HUE_BIT]) begin
            if (c[1:0] == MODE_BLINK && ph) r = 2'b10;
            if (c[1:0] == MODE_STEADY) r = 2'b01;
        end else begin
            if (c[1:0] == MODE_BLINK && ph) r = 2'b01;
            if (c[1:0] == MODE_STEADY) r = 2'b10;
        end
        return r;
    endfunction

    // state decode from sleep and power-good inputs
    always_comb begin
        nxt_state = PWR_S5;
        if (!soft_off_sleep_n) nxt_state = PWR_S5;
        else if (!suspend_ram_sleep_n)
            nxt_state = supply_power_good ? PWR_S3_HOLD : PWR_S3_LOW;
        else
            nxt_state = supply_power_good ? PWR_S0_ON : PWR_S0_LOW;
    end

    always_ff @(posedge core_clk) begin
        if (rst) state_ff <= PWR_S5;
        else state_ff <= nxt_state;
    end

    // low bits owned by hardware except in S0 with power-good
    always_ff @(posedge core_clk) begin
        if (rst) begin
            led_ctrl_ff <= LED_CTRL_RST;
        end else begin
            case (nxt_state)
                PWR_S5: begin
                    led_ctrl_ff[2:0] <= {1'b0, MODE_OFF};
                end
                PWR_S3_LOW: begin
                    led_ctrl_ff[2:0] <= {1'b1, MODE_BLINK};
                end
                PWR_S0_LOW: begin
                    led_ctrl_ff[2:0] <= {1'b0, MODE_BLINK};
                end
                PWR_S3_HOLD: begin
                    led_ctrl_ff[2:0] <= led_ctrl_ff[2:0];
                end
                default: begin
                    if (reg_wr && reg_addr == ADDR_LED_CTRL)
                        led_ctrl_ff[2:0] <= reg_wdata[2:0];
                end
            endcase
            if (main_rail_rst)
                led_ctrl_ff[BOOT_BIT] <= 1'b0;
            else if (nxt_state == PWR_S0_ON && reg_wr
                     && reg_addr == ADDR_LED_CTRL)
                led_ctrl_ff[BOOT_BIT] <= reg_wdata[BOOT_BIT];
        end
    end

    // polarity bits, inverted by default
    always_ff @(posedge core_clk) begin
        if (rst) gpio_inv_ff <= GPIO_CFG_RST;
        else if (reg_wr && reg_addr == ADDR_GPIO_CFG)
            gpio_inv_ff <= reg_wdata[1:0];
    end

    // half-second blink timebase
    always_ff @(posedge core_clk) begin
        if (rst) begin
            blink_cnt_ff <= '0;
            blink_ph_ff  <= 1'b0;
        end else if (blink_cnt_ff == CNT_W'(HALF_BLINK_CYC - 1)) begin
            blink_cnt_ff <= '0;
            blink_ph_ff  <= ~blink_ph_ff;
        end else begin
            blink_cnt_ff <= blink_cnt_ff + 1'b1;
        end
    end

    always_comb begin
        {drive2, drive1} = lit_of(led_ctrl_ff, blink_ph_ff);
        pin1 = gpio_inv_ff[0] ? ~drive1 : drive1;
        pin2 = gpio_inv_ff[1] ? ~drive2 : drive2;
    end

    // open drain: drive only the low level
    always_ff @(posedge core_clk) begin
        if (rst) begin
            first_indicator_out  <= 1'b0;
            first_indicator_oe   <= 1'b0;
            second_indicator_out <= 1'b0;
            second_indicator_oe  <= 1'b0;
        end else begin
            first_indicator_out  <= 1'b0;
            first_indicator_oe   <= ~pin1;
            second_indicator_out <= 1'b0;
            second_indicator_oe  <= ~pin2;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == ADDR_LED_CTRL)
                reg_rdata <= {4'h0, led_ctrl_ff};
            else if (reg_addr == ADDR_GPIO_CFG)
                reg_rdata <= {6'h00, gpio_inv_ff};
            else if (reg_addr == ADDR_STATUS)
                reg_rdata <= {3'h0, state_ff, second_indicator_in,
                              first_indicator_in};
            else
                reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // bus steps used by the checks below
    sequence s_rd_ctrl;
        reg_rd && reg_addr == ADDR_LED_CTRL;
    endsequence

    sequence s_rd_gpio;
        reg_rd && reg_addr == ADDR_GPIO_CFG;
    endsequence

    sequence s_rd_status;
        reg_rd && reg_addr == ADDR_STATUS;
    endsequence

    sequence s_wr_gpio;
        reg_wr && reg_addr == ADDR_GPIO_CFG;
    endsequence

    sequence s_wr_ctrl_on;
        reg_wr && reg_addr == ADDR_LED_CTRL && nxt_state == PWR_S0_ON
        && !main_rail_rst;
    endsequence

    sequence s_wr_ctrl_refused;
        reg_wr && reg_addr == ADDR_LED_CTRL && nxt_state != PWR_S0_ON
        && !main_rail_rst;
    endsequence

    a_s5_forces_off: assert property (@(posedge core_clk)
        disable iff (rst)
        !soft_off_sleep_n |=> led_ctrl_ff[2:0] == 3'h0)
        else $error("S5 did not load off");

    a_s3_blinks_second: assert property (@(posedge core_clk)
        disable iff (rst)
        soft_off_sleep_n && !suspend_ram_sleep_n && !supply_power_good
        |=> led_ctrl_ff[2:0] == 3'h5)
        else $error("S3 without power-good wrong");

    a_s0_blinks_first: assert property (@(posedge core_clk)
        disable iff (rst)
        soft_off_sleep_n && suspend_ram_sleep_n && !supply_power_good
        |=> led_ctrl_ff[2:0] == 3'h1)
        else $error("S0 without power-good wrong");

    a_s3_hold_prev: assert property (@(posedge core_clk)
        disable iff (rst)
        soft_off_sleep_n && !suspend_ram_sleep_n && supply_power_good
        && !main_rail_rst |=> $stable(led_ctrl_ff))
        else $error("S3 hold changed register");

    a_boot_clear: assert property (@(posedge core_clk)
        disable iff (rst)
        main_rail_rst |=> !led_ctrl_ff[BOOT_BIT])
        else $error("boot flag not cleared");

    a_write_in_s0: assert property (@(posedge core_clk)
        disable iff (rst)
        soft_off_sleep_n && suspend_ram_sleep_n && supply_power_good
        && reg_wr && reg_addr == ADDR_LED_CTRL
        |=> led_ctrl_ff[2:0] == $past(reg_wdata[2:0]))
        else $error("software write lost");

    a_write_boot: assert property (@(posedge core_clk)
        disable iff (rst)
        s_wr_ctrl_on |=> led_ctrl_ff[BOOT_BIT] == $past(reg_wdata[3]))
        else $error("boot flag write lost");

    a_refused_boot: assert property (@(posedge core_clk)
        disable iff (rst)
        s_wr_ctrl_refused |=> $stable(led_ctrl_ff[BOOT_BIT]))
        else $error("boot flag written outside S0");

    a_steady_second: assert property (@(posedge core_clk)
        disable iff (rst)
        led_ctrl_ff == 4'hf && gpio_inv_ff == 2'h3
        |=> second_indicator_oe && !first_indicator_oe)
        else $error("all ones not second steady");

    a_steady_first: assert property (@(posedge core_clk)
        disable iff (rst)
        led_ctrl_ff == 4'h3 && gpio_inv_ff == 2'h3
        |=> first_indicator_oe && !second_indicator_oe)
        else $error("mode 11 hue 0 not first steady");

    a_alt_mode_off: assert property (@(posedge core_clk)
        disable iff (rst)
        led_ctrl_ff[1:0] == MODE_OFF_ALT && gpio_inv_ff == 2'h3
        |=> !first_indicator_oe && !second_indicator_oe)
        else $error("mode 10 drives a pin");

    a_off_no_drive: assert property (@(posedge core_clk)
        disable iff (rst)
        led_ctrl_ff[1:0] == MODE_OFF && gpio_inv_ff == 2'h3
        |=> !first_indicator_oe && !second_indicator_oe)
        else $error("off mode drives a pin");

    a_one_hue_only: assert property (@(posedge core_clk)
        disable iff (rst)
        gpio_inv_ff == 2'h3
        |=> !(first_indicator_oe && second_indicator_oe))
        else $error("both hues driven");

    a_out_level_low: assert property (@(posedge core_clk)
        disable iff (rst)
        !first_indicator_out && !second_indicator_out)
        else $error("open drain output drives high");

    a_reset_quiet: assert property (@(posedge core_clk)
        rst |=> !first_indicator_oe && !second_indicator_oe)
        else $error("pin driven after reset");

    a_reset_polarity: assert property (@(posedge core_clk)
        rst |=> gpio_inv_ff == GPIO_CFG_RST)
        else $error("polarity not inverted after reset");

    a_gpio_write: assert property (@(posedge core_clk)
        disable iff (rst)
        s_wr_gpio |=> gpio_inv_ff == $past(reg_wdata[1:0]))
        else $error("polarity write lost");

    a_blink_period: assert property (@(posedge core_clk)
        disable iff (rst)
        blink_cnt_ff == CNT_W'(HALF_BLINK_CYC - 1)
        |=> blink_ph_ff != $past(blink_ph_ff))
        else $error("blink phase not toggled");

    a_blink_hold: assert property (@(posedge core_clk)
        disable iff (rst)
        blink_cnt_ff != CNT_W'(HALF_BLINK_CYC - 1)
        |=> $stable(blink_ph_ff))
        else $error("blink phase moved early");

    a_blink_cnt_range: assert property (@(posedge core_clk)
        disable iff (rst)
        blink_cnt_ff <= CNT_W'(HALF_BLINK_CYC - 1))
        else $error("blink counter overran");

    a_state_follows: assert property (@(posedge core_clk)
        disable iff (rst)
        1'b1 |=> state_ff == $past(nxt_state))
        else $error("state not taken from inputs");

    a_rd_ctrl_data: assert property (@(posedge core_clk)
        disable iff (rst)
        s_rd_ctrl |=> reg_rdata == {4'h0, $past(led_ctrl_ff)})
        else $error("control read data wrong");

    a_rd_gpio_data: assert property (@(posedge core_clk)
        disable iff (rst)
        s_rd_gpio |=> reg_rdata == {6'h00, $past(gpio_inv_ff)})
        else $error("polarity read data wrong");

    a_rd_status_st: assert property (@(posedge core_clk)
        disable iff (rst)
        s_rd_status |=> reg_rdata[4:2] == $past(state_ff))
        else $error("status state code wrong");

    a_rdata_idle: assert property (@(posedge core_clk)
        disable iff (rst)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
endmodule

//--- core/led_indicator_pkg.sv
// Purpose: constants for the bi-colour indicator controller
// Assumes: 40 MHz core clock
// Notes:   register map offsets chosen for this block
package led_indicator_pkg;
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned HALF_BLINK_MS = 500;
    localparam int unsigned HALF_BLINK_CYC =
        CLK_HZ / 1000 * HALF_BLINK_MS;
    localparam int unsigned CNT_W         = 25;
    localparam logic [3:0] ADDR_LED_CTRL  = 4'h0;
    localparam logic [3:0] ADDR_GPIO_CFG  = 4'h4;
    localparam logic [3:0] ADDR_STATUS    = 4'h8;
    localparam logic [3:0] LED_CTRL_RST   = 4'h0;
    localparam logic [1:0] GPIO_CFG_RST   = 2'h3;
    localparam int unsigned BOOT_BIT      = 3;
    localparam int unsigned HUE_BIT       = 2;
    localparam logic [1:0] MODE_OFF       = 2'h0;
    localparam logic [1:0] MODE_BLINK     = 2'h1;
    localparam logic [1:0] MODE_OFF_ALT   = 2'h2;
    localparam logic [1:0] MODE_STEADY    = 2'h3;
    typedef enum logic [2:0] {
        PWR_S5      = 3'b000,
        PWR_S3_LOW  = 3'b001,
        PWR_S3_HOLD = 3'b011,
        PWR_S0_LOW  = 3'b010,
        PWR_S0_ON   = 3'b110
    } pwr_state_t;
endpackage

//--- verification/bicolor_led_state_control_tb_top.sv
// Purpose: self-checking bench for the indicator controller
// Assumes: blink phase stays 0 in this short run
// Notes:   reads queue expectations, a watcher compares
`timescale 1ns/1ps
module bicolor_led_state_control_tb_top
    import led_indicator_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        main_rail_rst = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        rd_d = 1'b0;
    logic [7:0]  reg_rdata;
    logic        slp5_n = 1'b0;
    logic        slp3_n = 1'b0;
    logic        pg = 1'b0;
    logic        p1, p2, o1, e1, o2, e2;
    logic [31:0] seed = 32'h8396;
    logic [7:0]  exp_q[$];
    int          failures = 0;
    int          checks_done = 0;

    always #12.5 core_clk = ~core_clk;

    bicolor_led_state_control uut (.core_clk(core_clk), .rst(rst),
        .main_rail_rst(main_rail_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .soft_off_sleep_n(slp5_n),
        .suspend_ram_sleep_n(slp3_n), .supply_power_good(pg),
        .first_indicator_in(p1), .second_indicator_in(p2),
        .first_indicator_out(o1), .first_indicator_oe(e1),
        .second_indicator_out(o2), .second_indicator_oe(e2));
    led_board_model board (.first_out(o1), .first_oe(e1),
        .second_out(o2), .second_oe(e2), .first_pin(p1), .second_pin(p2));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // status in S0 with power-good, blink still unlit
    function automatic logic [7:0] st_on(input logic [3:0] v);
        logic s;
        s = (v[1:0] == MODE_STEADY);
        return {3'b000, 3'b110, ~(s & v[3]), ~(s & ~v[3])};
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask
    task automatic pwr(input logic s5, input logic s3, input logic g);
        @(posedge core_clk);
        slp5_n <= s5;
        slp3_n <= s3;
        pg <= g;
        repeat (4) @(posedge core_clk);
    endtask

    always @(posedge core_clk) begin
        rd_d <= reg_rd;
        if (rd_d && exp_q.size() > 0) begin
            chk(reg_rdata, exp_q.pop_front());
        end
    end

    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        rd(ADDR_LED_CTRL, {4'h0, LED_CTRL_RST});
        rd(ADDR_GPIO_CFG, {6'h00, GPIO_CFG_RST});
        rd(4'hc, 8'h00);
        rd(ADDR_STATUS, 8'h03);
        pwr(1'b1, 1'b0, 1'b0);
        rd(ADDR_LED_CTRL, 8'h05);
        rd(ADDR_STATUS, 8'h07);
        pwr(1'b1, 1'b0, 1'b1);
        wr(ADDR_LED_CTRL, 8'h0c);
        rd(ADDR_LED_CTRL, 8'h05);
        rd(ADDR_STATUS, 8'h0f);
        pwr(1'b1, 1'b1, 1'b0);
        rd(ADDR_LED_CTRL, 8'h01);
        rd(ADDR_STATUS, 8'h0b);
        pwr(1'b1, 1'b1, 1'b1);
        for (int v = 0; v < 16; v++) begin
            seed = xs(seed);
            wr(ADDR_LED_CTRL, {seed[3:0], v[3:0]});
            rd(ADDR_LED_CTRL, {4'h0, v[3:0]});
            rd(ADDR_STATUS, st_on(v[3:0]));
        end
        wr(ADDR_GPIO_CFG, 8'h00);
        rd(ADDR_STATUS, 8'h1a);
        wr(ADDR_GPIO_CFG, {6'h00, GPIO_CFG_RST});
        @(posedge core_clk);
        main_rail_rst <= 1'b1;
        @(posedge core_clk);
        main_rail_rst <= 1'b0;
        rd(ADDR_LED_CTRL, 8'h07);
        rd(ADDR_STATUS, 8'h1a);
        pwr(1'b0, 1'b1, 1'b1);
        rd(ADDR_LED_CTRL, 8'h00);
        rd(ADDR_STATUS, 8'h03);
        for (int i = 0; i < 8 && exp_q.size() > 0; i++) begin
            @(posedge core_clk);
        end
        if (exp_q.size() > 0) begin
            failures++;
        end
        test_done();
    end
endmodule

//--- verification/led_board_model.sv
// Purpose: board side of the two indicator pins
// Assumes: open-drain pins with pull-ups
// Notes:   pin levels feed back to the pin inputs
`timescale 1ns/1ps
module led_board_model (
    input  wire logic first_out,
    input  wire logic first_oe,
    input  wire logic second_out,
    input  wire logic second_oe,
    output logic      first_pin,
    output logic      second_pin
);
    // released line is pulled high
    assign first_pin  = first_oe ? first_out : 1'b1;
    assign second_pin = second_oe ? second_out : 1'b1;
endmodule
